/* pci_target_config_regs_tb.sv */
// self-checking bench of the configuration registers
`timescale 1ns/10ps
`default_nettype none
module pci_target_config_regs_tb;
   import pcicfg_pkg::*;
   logic clk, reset, cfgWr, cfgRd, memHit, ioHit, intAOut, extN;
   // two-state so the first edge never sees an unknown pending read
   bit rdPend;
   logic [7:0] cfgAddr, irqLine;
   logic [31:0] cfgWrData, cfgRdData, pciAddr, b0, b1, r, base;
   logic [3:0] cfgByteEn;
   logic [15:0] cmdWord;
   logic [2:0] ev;
   int err_total, n_tests, cyc, seed;
   logic [31:0] expQ[$];
   int pos[3] = '{27, 30, 31};
   pcicfg_host pcicfg_host_i (.clk(clk), .cfgWr(cfgWr), .cfgRd(cfgRd), .cfgAddr(cfgAddr),
      .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn));
   pcicfg_regs pcicfg_regs_i (.clk(clk), .reset(reset), .cfgWr(cfgWr), .cfgRd(cfgRd),
      .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn),
      .cfgRdData(cfgRdData), .cmdWord(cmdWord), .targetAbort(ev[0]), .serrDrive(ev[1]),
      .parityErr(ev[2]), .ext_irq_in_n(extN), .pciAddr(pciAddr), .memHit(memHit),
      .ioHit(ioHit), .intAOut(intAOut), .irqLine(irqLine));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      expQ.push_back(exp);
      pcicfg_host_i.rd(a);
   endtask
   task automatic hitChk(input logic [31:0] a, input logic [15:0] cmd);
      @(posedge clk);
      pciAddr <= a;
      cmdWord <= cmd;
      #1;
      check({31'h0, memHit}, {31'h0, a[31:24] == b0[31:24] && cmd[1]});
      check({31'h0, ioHit}, {31'h0, a[31:8] == b1[31:8] && cmd[0]});
   endtask
   // read data lands one cycle after the taking edge
   always @(posedge clk) begin
      if (rdPend) check(cfgRdData, expQ.pop_front());
      rdPend <= cfgRd;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      reset = 1'b1;
      seed = 32'h9124a25d;
      cmdWord = 16'h0003;
      ev = 3'h0;
      extN = 1'b1;
      pciAddr = 32'h0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      base = {16'h0420, 16'h0003};
      // ----------------------------------------
      // status flags
      // ----------------------------------------
      rdChk(OFS_STATUS, base);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         ev <= 3'h1 << i;
         @(posedge clk);
         ev <= 3'h0;
         rdChk(OFS_STATUS, base | (32'h1 << pos[i]));
         pcicfg_host_i.wr(OFS_STATUS, 32'h3000_0000, 4'hF);
         rdChk(OFS_STATUS, base | (32'h1 << pos[i]));
         pcicfg_host_i.wr(OFS_STATUS, 32'h1 << pos[i], 4'hF);
         rdChk(OFS_STATUS, base);
      end
      // ----------------------------------------
      // base address registers
      // ----------------------------------------
      rdChk(OFS_MEMBASE, 32'h0000_0008);
      rdChk(OFS_IOBASE, 32'h0000_0001);
      r = $random(seed);
      pcicfg_host_i.wr(OFS_MEMBASE, 32'hFFFF_FFFF, 4'hF);
      rdChk(OFS_MEMBASE, 32'hFF00_0008);
      pcicfg_host_i.wr(OFS_MEMBASE, r, 4'h7);
      rdChk(OFS_MEMBASE, 32'hFF00_0008);
      pcicfg_host_i.wr(OFS_MEMBASE, r, 4'h8);
      b0 = {r[31:24], 24'h000008};
      rdChk(OFS_MEMBASE, b0);
      pcicfg_host_i.wr(OFS_IOBASE, 32'hFFFF_FFFF, 4'hF);
      rdChk(OFS_IOBASE, 32'hFFFF_FF01);
      r = $random(seed);
      pcicfg_host_i.wr(OFS_IOBASE, r, 4'hE);
      b1 = {r[31:8], 8'h01};
      rdChk(OFS_IOBASE, b1);
      r = $random(seed);
      hitChk({b0[31:24], r[23:0]}, 16'h0003);
      hitChk({b0[31:24] ^ 8'h01, r[23:0]}, 16'h0003);
      hitChk({b0[31:24], r[23:0]}, 16'h0001);
      hitChk({b1[31:8], r[7:0]}, 16'h0003);
      hitChk({b1[31:9], ~b1[8], r[7:0]}, 16'h0003);
      hitChk({b1[31:8], r[7:0]}, 16'h0002);
      hitChk(r, 16'h0003);
      // ----------------------------------------
      // interrupt, identification, unmapped
      // ----------------------------------------
      rdChk(OFS_IRQ, 32'h0000_0001);
      pcicfg_host_i.wr(OFS_IRQ, 32'hFFFF_A5FF, 4'hF);
      rdChk(OFS_IRQ, 32'h0000_A501);
      check({24'h0, irqLine}, 32'h0000_00A5);
      rdChk(OFS_EXTIRQ, 32'h0);
      pcicfg_host_i.wr(OFS_EXTIRQ, 32'hFFFF_FFFF, 4'hF);
      rdChk(OFS_EXTIRQ, 32'h0000_8000);
      check({31'h0, intAOut}, 32'h0);
      @(posedge clk);
      extN <= 1'b0;
      @(posedge clk);
      extN <= 1'b1;
      rdChk(OFS_EXTIRQ, 32'h0000_C000);
      check({31'h0, intAOut}, 32'h1);
      pcicfg_host_i.wr(OFS_EXTIRQ, 32'h0000_C000, 4'hF);
      rdChk(OFS_EXTIRQ, 32'h0000_8000);
      check({31'h0, intAOut}, 32'h0);
      pcicfg_host_i.wr(OFS_EXTIRQ, 32'h0, 4'hF);
      @(posedge clk);
      extN <= 1'b0;
      @(posedge clk);
      extN <= 1'b1;
      rdChk(OFS_EXTIRQ, 32'h0000_4000);
      check({31'h0, intAOut}, 32'h0);
      pcicfg_host_i.wr(OFS_ID, 32'hFFFF_FFFF, 4'hF);
      rdChk(OFS_ID, {DEV_ID_DEF, VEN_ID_DEF});
      pcicfg_host_i.wr(OFS_CLASS, 32'hFFFF_FFFF, 4'hF);
      rdChk(OFS_CLASS, {CLASS_DEF, REV_ID_DEF});
      rdChk(OFS_SUBSYS, {SUBSYS_ID_DEF, SUBVEN_ID_DEF});
      pcicfg_host_i.wr(8'h40, 32'hFFFF_FFFF, 4'hF);
      rdChk(8'h40, 32'h0);
      // ----------------------------------------
      // mid-run reset clears flags and storage
      // ----------------------------------------
      @(posedge clk);
      ev <= 3'h7;
      extN <= 1'b0;
      @(posedge clk);
      ev <= 3'h0;
      extN <= 1'b1;
      rdChk(OFS_STATUS, base | 32'hC800_0000);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdChk(OFS_STATUS, base);
      rdChk(OFS_EXTIRQ, 32'h0);
      rdChk(OFS_MEMBASE, 32'h0000_0008);
      rdChk(OFS_IRQ, 32'h0000_0001);
      check({24'h0, irqLine}, 32'h0);
      check({31'h0, intAOut}, 32'h0);
      repeat (4) @(posedge clk);
      check(expQ.size(), 32'h0);
      print_verdict();
   end
endmodule // pci_target_config_regs_tb
`default_nettype wire

/* pcicfg_bar.sv */
// one base address register: storage, readback and address hit
`timescale 1ns/10ps
`default_nettype none
module pcicfg_bar
   import pcicfg_pkg::*;
#(
   parameter int WIDTH = 24,
   parameter logic [3:0] LOW_BITS = 4'h8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic wrEn,
   input wire logic [31:0] wrData,
   input wire logic [3:0] byteEn,
   input wire logic [31:0] pciAddr,
   output logic [31:0] rdValue,
   output logic hit
);
   typedef struct packed {
      logic [31:0] base;
   } pcicfg_bar_t;
   pcicfg_bar_t state_ff;
   pcicfg_bar_t nxt_state;
   logic [31:0] wrMask;
   logic [31:0] laneMask;

   // writable split follows the window size
   assign wrMask = ~((32'h1 << WIDTH) - 32'h1);
   assign laneMask = {{8{byteEn[3]}}, {8{byteEn[2]}}, {8{byteEn[1]}}, {8{byteEn[0]}}};

   always_comb begin
      nxt_state = state_ff;
      if (wrEn) begin
         // only upper window bits take data
         nxt_state.base = (state_ff.base & ~(wrMask & laneMask)) | (wrData & wrMask & laneMask);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // low bits hardwired: type and prefetch or io marker
   assign rdValue = (state_ff.base & wrMask) | {28'h0000000, LOW_BITS};
   assign hit = ((pciAddr & wrMask) == (state_ff.base & wrMask));

   a_bar_lowfix: assert property (@(posedge clk) disable iff (reset)
      rdValue[3:0] == LOW_BITS) else $error("bar low bits not fixed");
   a_bar_hold: assert property (@(posedge clk) disable iff (reset)
      !$past(wrEn) |-> $stable(rdValue)) else $error("bar changed without write");
endmodule // pcicfg_bar
`default_nettype wire

/* pcicfg_flag.sv */
// sticky flag set by hardware, cleared by writing one; set wins
`timescale 1ns/10ps
`default_nettype none
module pcicfg_flag (
   input wire logic clk,
   input wire logic reset,
   input wire logic setEv,
   input wire logic clrOne,
   output logic flag
);
   typedef struct packed {
      logic flag;
   } pcicfg_flag_t;
   pcicfg_flag_t state_ff;
   pcicfg_flag_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (setEv) begin
         nxt_state.flag = 1'b1;
      end else if (clrOne) begin
         nxt_state.flag = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign flag = state_ff.flag;

   a_flag_setwins: assert property (@(posedge clk) disable iff (reset)
      setEv |=> flag) else $error("set event lost");
   a_flag_noclr: assert property (@(posedge clk) disable iff (reset)
      (flag && !clrOne) |=> flag) else $error("flag cleared without write one");
endmodule // pcicfg_flag
`default_nettype wire

/* pcicfg_host.sv */
// host model issuing configuration reads and writes
`timescale 1ns/10ps
`default_nettype none
module pcicfg_host (
   input wire logic clk,
   output logic cfgWr,
   output logic cfgRd,
   output logic [7:0] cfgAddr,
   output logic [31:0] cfgWrData,
   output logic [3:0] cfgByteEn
);
   initial begin
      cfgWr = 1'b0;
      cfgRd = 1'b0;
      cfgAddr = 8'h00;
      cfgWrData = 32'h0;
      cfgByteEn = 4'h0;
   end
   // released lines get the inverse so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      cfgWr <= 1'b1;
      cfgAddr <= a;
      cfgWrData <= d;
      cfgByteEn <= be;
      @(posedge clk);
      cfgWr <= 1'b0;
      cfgAddr <= ~a;
      cfgWrData <= ~d;
      cfgByteEn <= ~be;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      cfgRd <= 1'b1;
      cfgAddr <= a;
      @(posedge clk);
      cfgRd <= 1'b0;
      cfgAddr <= ~a;
   endtask
endmodule // pcicfg_host
`default_nettype wire

/* pcicfg_pkg.sv */
// package of offsets, fields and constants for the pci target config registers
package pcicfg_pkg;
   // ----------------------------------------
   // configuration offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_ID = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CLASS = 8'h08;
   localparam logic [7:0] OFS_MEMBASE = 8'h10;
   localparam logic [7:0] OFS_IOBASE = 8'h14;
   localparam logic [7:0] OFS_SUBSYS = 8'h2C;
   localparam logic [7:0] OFS_IRQ = 8'h3C;
   localparam logic [7:0] OFS_EXTIRQ = 8'h48;
   // ----------------------------------------
   // status word fields (bit within the 16-bit status half)
   // ----------------------------------------
   localparam int ST_SIG_TABORT = 11;
   localparam int ST_RCV_TABORT = 12;
   localparam int ST_RCV_MABORT = 13;
   localparam int ST_SIG_SERR = 14;
   localparam int ST_DET_PERR = 15;
   localparam logic [10:0] ST_LOW_FIXED = 11'h400;
   localparam int ST_66MHZ_BIT = 5;
   // ----------------------------------------
   // base address fields
   // ----------------------------------------
   localparam logic [3:0] MEM_LOW_BITS = 4'h8;
   localparam logic [3:0] MEM_LOW_NOPF = 4'h0;
   localparam logic [1:0] IO_LOW_BITS = 2'h1;
   localparam int MEM_WIDTH_DEF = 24;
   localparam int IO_WIDTH_DEF = 8;
   // ----------------------------------------
   // interrupt register fields
   // ----------------------------------------
   localparam logic [7:0] IRQ_PIN_A = 8'h01;
   localparam logic [7:0] IRQ_LINE_RST = 8'h00;
   localparam int EXT_PEND_BIT = 14;
   localparam int EXT_EN_BIT = 15;
   // ----------------------------------------
   // identification defaults (values arbitrary)
   // ----------------------------------------
   localparam logic [15:0] DEV_ID_DEF = 16'h0001;
   localparam logic [15:0] VEN_ID_DEF = 16'h0002;
   localparam logic [7:0] REV_ID_DEF = 8'h03;
   localparam logic [23:0] CLASS_DEF = 24'h000004;
   localparam logic [15:0] SUBSYS_ID_DEF = 16'h0005;
   localparam logic [15:0] SUBVEN_ID_DEF = 16'h0006;
endpackage : pcicfg_pkg

/* pcicfg_regs.sv */
// configuration-space registers of the pci target
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - status flags clear only by writing one; zero leaves them.
// - received target and master abort bits always read zero.
// - signaled system error flag resets zero, sets when serr driven.
// - detected parity error sets on any parity error, ignoring response bit.
// - memory base reads memory space, type 00, prefetchable bit 3.
// - 16 MB default: bits 23-4 zero, 31-24 writable, compared for hit.
// - writable/hardwired split in both bars follows configured window size.
// - io base only in second bar: bit0 one, bit1 zero, low zeros.
// - io base bits 31-8 writable and compared to address for hit.
// - interrupt pin byte reads 01, meaning line a.
// - interrupt line byte is plain storage affecting nothing.
// - interrupt register may be left out without interrupt capability.
// - 48h bit 14 pending: resets zero, sets on input, write one clears.
// - 48h bit 15 enables external interrupt support.
// - 48h other bits read zero.
// - identification fields are read-only build constants.
// - signaled target abort flag resets zero, sets on target abort.
module pcicfg_regs
   import pcicfg_pkg::*;
#(
   parameter int MEM_WIDTH = MEM_WIDTH_DEF,
   parameter logic BAR1_ENABLE = 1'b1,
   parameter logic BAR1_IS_MEM = 1'b0,
   parameter int BAR1_WIDTH = IO_WIDTH_DEF,
   parameter logic BAR1_PREFETCH = 1'b1,
   parameter logic IRQ_ENABLE = 1'b1,
   parameter logic MHZ66 = 1'b1,
   parameter logic [15:0] DEV_ID = DEV_ID_DEF,
   parameter logic [15:0] VEN_ID = VEN_ID_DEF,
   parameter logic [7:0] REV_ID = REV_ID_DEF,
   parameter logic [23:0] CLASS_CODE = CLASS_DEF,
   parameter logic [15:0] SUBSYS_ID = SUBSYS_ID_DEF,
   parameter logic [15:0] SUBVEN_ID = SUBVEN_ID_DEF
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cfgWr,
   input wire logic cfgRd,
   input wire logic [7:0] cfgAddr,
   input wire logic [31:0] cfgWrData,
   input wire logic [3:0] cfgByteEn,
   output logic [31:0] cfgRdData,
   input wire logic [15:0] cmdWord,
   input wire logic targetAbort,
   input wire logic serrDrive,
   input wire logic parityErr,
   input wire logic ext_irq_in_n,
   input wire logic [31:0] pciAddr,
   output logic memHit,
   output logic ioHit,
   output logic intAOut,
   output logic [7:0] irqLine
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] rdData;
      logic [7:0] irqLine;
      logic extEnable;
   } pcicfg_regs_t;
   pcicfg_regs_t state_ff;
   pcicfg_regs_t nxt_state;

   logic [31:0] memRd;
   logic [31:0] bar1Rd;
   logic memMatch;
   logic bar1Match;
   logic wrStatus;
   logic wrMem;
   logic wrBar1;
   logic wrIrq;
   logic wrExt;
   logic sigTabort;
   logic sigSerr;
   logic detPerr;
   logic extPend;
   logic [15:0] statusWord;
   logic [31:0] rdMux;
   // line byte of the write data, tapped for the line storage check
   logic [7:0] lineWrByte;

   localparam logic [3:0] MEM0_LOW = MEM_LOW_BITS;
   localparam logic [3:0] BAR1_LOW = !BAR1_IS_MEM ? {2'h0, IO_LOW_BITS} :
      (BAR1_PREFETCH ? MEM_LOW_BITS : MEM_LOW_NOPF);

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   assign wrStatus = cfgWr && (cfgAddr == OFS_STATUS) && cfgByteEn[3];
   assign wrMem = cfgWr && (cfgAddr == OFS_MEMBASE);
   assign wrBar1 = cfgWr && (cfgAddr == OFS_IOBASE) && BAR1_ENABLE;
   assign wrIrq = cfgWr && (cfgAddr == OFS_IRQ) && cfgByteEn[1] && IRQ_ENABLE;
   assign wrExt = cfgWr && (cfgAddr == OFS_EXTIRQ) && cfgByteEn[1];
   assign lineWrByte = cfgWrData[15:8];

   // ----------------------------------------
   // base address registers
   // ----------------------------------------
   pcicfg_bar #(
      .WIDTH(MEM_WIDTH),
      .LOW_BITS(MEM0_LOW)
   ) u_bar0 (
      .clk(clk),
      .reset(reset),
      .wrEn(wrMem),
      .wrData(cfgWrData),
      .byteEn(cfgByteEn),
      .pciAddr(pciAddr),
      .rdValue(memRd),
      .hit(memMatch)
   );

   // io type only allowed on the second bar
   pcicfg_bar #(
      .WIDTH(BAR1_WIDTH),
      .LOW_BITS(BAR1_LOW)
   ) u_bar1 (
      .clk(clk),
      .reset(reset),
      .wrEn(wrBar1),
      .wrData(cfgWrData),
      .byteEn(cfgByteEn),
      .pciAddr(pciAddr),
      .rdValue(bar1Rd),
      .hit(bar1Match)
   );

   // hit qualified by command space enables; bar1 memory hits join memHit
   assign memHit = cmdWord[1] && (memMatch || (BAR1_ENABLE && BAR1_IS_MEM && bar1Match));
   assign ioHit = cmdWord[0] && BAR1_ENABLE && !BAR1_IS_MEM && bar1Match;

   // ----------------------------------------
   // status flags: bits 27, 30 and 31 of dword 04h, then the 48h pending flag at bit 14
   // ----------------------------------------
   pcicfg_flag u_sigtabort (
      .clk(clk),
      .reset(reset),
      .setEv(targetAbort),
      .clrOne(wrStatus && cfgWrData[16 + ST_SIG_TABORT]),
      .flag(sigTabort)
   );

   pcicfg_flag u_sigserr (
      .clk(clk),
      .reset(reset),
      .setEv(serrDrive),
      .clrOne(wrStatus && cfgWrData[16 + ST_SIG_SERR]),
      .flag(sigSerr)
   );

   // parity response bit deliberately not consulted
   pcicfg_flag u_detperr (
      .clk(clk),
      .reset(reset),
      .setEv(parityErr),
      .clrOne(wrStatus && cfgWrData[16 + ST_DET_PERR]),
      .flag(detPerr)
   );

   // external interrupt pending, level-set while input low
   pcicfg_flag u_extpend (
      .clk(clk),
      .reset(reset),
      .setEv(!ext_irq_in_n),
      .clrOne(wrExt && cfgWrData[EXT_PEND_BIT]),
      .flag(extPend)
   );

   always_comb begin
      statusWord = {5'h00, ST_LOW_FIXED};
      statusWord[ST_66MHZ_BIT] = MHZ66;
      statusWord[ST_SIG_TABORT] = sigTabort;
      statusWord[ST_RCV_TABORT] = 1'b0;
      statusWord[ST_RCV_MABORT] = 1'b0;
      statusWord[ST_SIG_SERR] = sigSerr;
      statusWord[ST_DET_PERR] = detPerr;
   end

   // ----------------------------------------
   // read multiplexer
   // ----------------------------------------
   always_comb begin
      case (cfgAddr)
         OFS_ID: rdMux = {DEV_ID, VEN_ID};
         OFS_STATUS: rdMux = {statusWord, cmdWord};
         OFS_CLASS: rdMux = {CLASS_CODE, REV_ID};
         OFS_MEMBASE: rdMux = memRd;
         OFS_IOBASE: rdMux = BAR1_ENABLE ? bar1Rd : 32'h00000000;
         OFS_SUBSYS: rdMux = {SUBSYS_ID, SUBVEN_ID};
         // pin constant, line storage
         OFS_IRQ: rdMux = IRQ_ENABLE ? {16'h0000, state_ff.irqLine, IRQ_PIN_A} : 32'h00000000;
         // reserved bits read zero
         OFS_EXTIRQ: rdMux = {16'h0000, state_ff.extEnable, extPend, 14'h0000};
         default: rdMux = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      if (cfgRd) begin
         nxt_state.rdData = rdMux;
      end
      if (wrIrq) begin
         nxt_state.irqLine = cfgWrData[15:8];
      end
      if (wrExt) begin
         nxt_state.extEnable = cfgWrData[EXT_EN_BIT];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign cfgRdData = state_ff.rdData;
   assign irqLine = state_ff.irqLine;
   // interrupt a, active high here; pad inverts
   assign intAOut = IRQ_ENABLE && extPend && state_ff.extEnable;

   // ----------------------------------------
   // checks: status flags
   // ----------------------------------------
   a_rcv_abort_zero: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_STATUS |=> cfgRdData[29:28] == 2'b00) else
      $error("received abort bits not zero");
   a_status_fixed: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_STATUS |=>
      cfgRdData[26:16] == {ST_LOW_FIXED[10:6], MHZ66, ST_LOW_FIXED[4:0]}) else
      $error("fixed status bits wrong");
   a_serr_sets: assert property (@(posedge clk) disable iff (reset)
      serrDrive |=> sigSerr) else $error("serr flag not set");
   a_serr_read: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_STATUS |=> cfgRdData[30] == $past(sigSerr)) else
      $error("serr flag read wrong");
   a_perr_sets: assert property (@(posedge clk) disable iff (reset)
      parityErr |=> detPerr) else $error("parity flag not set");
   a_perr_read: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_STATUS |=> cfgRdData[31] == $past(detPerr)) else
      $error("parity flag read wrong");
   a_tabort_sets: assert property (@(posedge clk) disable iff (reset)
      targetAbort |=> sigTabort) else $error("target abort flag not set");
   a_tabort_read: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_STATUS |=> cfgRdData[27] == $past(sigTabort)) else
      $error("target abort flag read wrong");
   a_serr_clear: assert property (@(posedge clk) disable iff (reset)
      wrStatus && cfgWrData[16 + ST_SIG_SERR] && !serrDrive |=> !sigSerr) else
      $error("serr flag not cleared by one");

   // ----------------------------------------
   // checks: base, identification, interrupt
   // ----------------------------------------
   a_mem_low: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_MEMBASE |=> cfgRdData[3:0] == MEM0_LOW) else
      $error("memory bar low bits wrong");
   a_bar1_low: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_IOBASE && BAR1_ENABLE |=> cfgRdData[3:0] == BAR1_LOW) else
      $error("second bar low bits wrong");
   a_mem_hit: assert property (@(posedge clk) disable iff (reset)
      memHit |-> cmdWord[1]) else $error("memory hit without enable");
   a_io_hit: assert property (@(posedge clk) disable iff (reset)
      ioHit |-> cmdWord[0] && !BAR1_IS_MEM) else $error("io hit without enable");
   a_id_const: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_ID |=> cfgRdData == {DEV_ID, VEN_ID}) else
      $error("identification not constant");
   a_pin_const: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_IRQ && IRQ_ENABLE |=> cfgRdData[7:0] == IRQ_PIN_A) else
      $error("interrupt pin wrong");
   a_line_write: assert property (@(posedge clk) disable iff (reset)
      wrIrq |=> irqLine == $past(lineWrByte)) else $error("line byte not stored");
   a_line_hold: assert property (@(posedge clk) disable iff (reset)
      !wrIrq |=> $stable(irqLine)) else $error("line byte changed without write");
   a_ext_reserved: assert property (@(posedge clk) disable iff (reset)
      cfgRd && cfgAddr == OFS_EXTIRQ |=> cfgRdData[13:0] == 14'h0000 &&
      cfgRdData[31:16] == 16'h0000) else $error("reserved bits not zero");
   // pending follows the input one edge later, so the pad sees it a cycle late
   a_ext_pend: assert property (@(posedge clk) disable iff (reset)
      !ext_irq_in_n |=> extPend) else $error("external pending not set");
   a_ext_clear: assert property (@(posedge clk) disable iff (reset)
      wrExt && cfgWrData[EXT_PEND_BIT] && ext_irq_in_n |=> !extPend) else
      $error("external pending not cleared");
   a_ext_enable: assert property (@(posedge clk) disable iff (reset)
      wrExt && cfgWrData[EXT_EN_BIT] |=> state_ff.extEnable) else $error("enable not set");
   a_ext_disable: assert property (@(posedge clk) disable iff (reset)
      wrExt && !cfgWrData[EXT_EN_BIT] |=> !state_ff.extEnable) else $error("enable not off");
   // enable only held when no write to 48h lands in the same cycle
   a_int_rise: assert property (@(posedge clk) disable iff (reset)
      !ext_irq_in_n && state_ff.extEnable && IRQ_ENABLE && !wrExt |=> intAOut) else
      $error("interrupt a not raised");
   a_int_drop: assert property (@(posedge clk) disable iff (reset)
      wrExt && !cfgWrData[EXT_EN_BIT] |=> !intAOut) else $error("interrupt a not dropped");
endmodule // pcicfg_regs
`default_nettype wire
